/* src/scl_pkg.sv */
/*
 * Shared constants and types for the serial configuration loader: the register
 * map of the AXI4-Lite slave, control bit positions, the memory word layout,
 * serial command framing and the carriers between the two clock domains.
 * Assumes a three-wire serial memory of 64 words of 16 bits.
 */
package scl_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CONFIG = 8'h04;
    localparam logic [7:0] OFF_BASE = 8'h08;
    localparam logic [7:0] OFF_STATION0 = 8'h0c;
    localparam logic [7:0] OFF_STATION1 = 8'h10;
    localparam logic [7:0] OFF_STATION2 = 8'h14;
    localparam logic [7:0] OFF_POINTER = 8'h18;
    localparam logic [7:0] OFF_GENERAL = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // control register bits
    localparam int CTL_SELECT_BIT = 0;
    localparam int CTL_LOAD_BIT = 1;
    localparam int CTL_SAVE_BIT = 2;
    // reset values of the loaded registers
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] BASE_RESET = 16'h0300;
    localparam logic [15:0] STATION_RESET = 16'h0000;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [15:0] GENERAL_RESET = 16'h0000;
    // memory layout
    localparam int NVM_WORDS = 64;
    localparam int NVM_ADDR_W = 6;
    localparam int NVM_DATA_W = 16;
    localparam int STRAP_STRIDE = 4;
    localparam logic [5:0] BASE_WORD_OFS = 6'h01;
    localparam logic [5:0] STATION_FIRST_WORD = 6'h20;
    localparam logic [2:0] STRAP_KEEP_DEFAULTS = 3'h7;
    // serial framing: start bit, opcode, address
    localparam logic [2:0] FRAME_READ = 3'b110;
    localparam logic [2:0] FRAME_WRITE = 3'b101;
    localparam logic [2:0] FRAME_ENABLE = 3'b100;
    localparam logic [5:0] ENABLE_ADDR = 6'h30;
    localparam logic [4:0] HEAD_BITS = 5'h09;
    localparam logic [4:0] WRITE_BITS = 5'h19;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [1:0] BOOT_SETTLE = 2'h3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        TGT_CONFIG, TGT_BASE, TGT_STATION0, TGT_STATION1, TGT_STATION2, TGT_GENERAL
    } scl_target_t;

    typedef enum logic [1:0] {
        JOB_LOAD_NORMAL, JOB_SAVE_NORMAL, JOB_LOAD_GENERAL, JOB_SAVE_GENERAL
    } scl_job_t;

    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic [15:0] data;
    } scl_cmd_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] addr;
        scl_target_t target;
    } scl_step_t;
endpackage

/* src/scl_loader.sv */
/*
 * Serial configuration loader: fetches configuration, base and station address
 * words from a three-wire serial memory after reset and on request, stores
 * configuration and base back, and gives word access through a pointer. Registers over AXI4-Lite on
 * aclk; the serial engine runs on link_clk and meets the register side through
 * toggle handshakes. Assumes the memory answers write completion on data-out.
 */
// What this block does
// - fetch address, base, configuration after every reset with memory present
// - configuration at strap*4, base at strap*4+1
// - station address always from words 20h-22h
// - strap 7 loads only station address
// - straps all high keep default base
// - memory is 64 sixteen-bit words, word transfers
// - normal load updates configuration, base, station address
// - normal save writes configuration and base back
// - low three control bits never loaded nor saved
// - general load reads pointer word into general register
// - general save writes general register at pointer
// - triggers read high while busy, clear when done
// - other register accesses, except status reads, blocked while transfer runs
// - absent memory: no accesses, defaults kept
`timescale 1ns/1ns
module scl_loader
    import scl_pkg::*;
#(
    parameter int ADDR_W = NVM_ADDR_W,
    parameter int DATA_W = NVM_DATA_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] board_offset_straps,
    input wire logic nvmem_present_pin,
    output logic [15:0] config_value,
    output logic [15:0] base_value,
    output logic [47:0] station_address,
    input wire logic link_clk,
    output logic nvm_cs,
    output logic nvm_sk,
    output logic nvm_di,
    input wire logic nvm_do
);
    if (ADDR_W != NVM_ADDR_W || DATA_W != NVM_DATA_W) begin : g_check
        $error("scl_loader serves only a 64 x 16 memory");
    end

    typedef enum {Q_BOOT, Q_IDLE, Q_STEP, Q_WAIT} scl_seq_t;
    typedef enum {E_IDLE, E_SHIFT, E_READ, E_GAP, E_WAIT, E_DONE} scl_eng_t;

    // register side state
    logic [15:0] config_reg, base_reg, pointer_reg, general_reg;
    logic [15:0] station_word [3];
    logic select_mode;
    logic busy;
    scl_seq_t seq;
    scl_job_t job;
    logic [2:0] step_idx;
    logic [1:0] boot_cnt;
    logic [2:0] strap_s1, strap_s2;
    logic present_s1, present_s2;
    scl_cmd_t cmd;
    logic req_tgl;
    logic done_s1, done_s2, done_seen;
    scl_step_t cur_step;

    // link side state
    logic lrst_s1, lrst_s2;
    logic req_s1, req_s2, req_seen;
    logic do_s1, do_s2;
    scl_eng_t eng;
    logic [1:0] ph;
    logic [4:0] bit_cnt;
    logic [24:0] shreg;
    logic [15:0] link_rdata;
    logic [1:0] stage;
    logic done_tgl;

    // axi holding registers
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    function automatic scl_step_t plan(input scl_job_t j, input logic [2:0] strap,
                                       input logic [2:0] idx, input logic [15:0] ptr);
        scl_step_t s;
        logic [5:0] cfg_word;
        s = '{valid: 1'b0, write: 1'b0, addr: 6'h00, target: TGT_CONFIG};
        cfg_word = 6'(strap * STRAP_STRIDE);
        case (j)
            JOB_LOAD_NORMAL: begin
                if (idx == 3'd0 && strap != STRAP_KEEP_DEFAULTS) begin
                    s = '{valid: 1'b1, write: 1'b0, addr: cfg_word, target: TGT_CONFIG};
                end else if (idx == 3'd1 && strap != STRAP_KEEP_DEFAULTS) begin
                    s = '{valid: 1'b1, write: 1'b0, addr: cfg_word + BASE_WORD_OFS,
                          target: TGT_BASE};
                end else if (idx >= 3'd2 && idx <= 3'd4) begin
                    s.valid = 1'b1;
                    s.addr = STATION_FIRST_WORD + 6'(idx - 3'd2);
                    s.target = scl_target_t'(3'(TGT_STATION0) + idx - 3'd2);
                end
            end
            JOB_SAVE_NORMAL: begin
                if (idx == 3'd0) begin
                    s = '{valid: 1'b1, write: 1'b1, addr: cfg_word, target: TGT_CONFIG};
                end else if (idx == 3'd1) begin
                    s = '{valid: 1'b1, write: 1'b1, addr: cfg_word + BASE_WORD_OFS,
                          target: TGT_BASE};
                end
            end
            JOB_LOAD_GENERAL: begin
                if (idx == 3'd0) begin
                    s = '{valid: 1'b1, write: 1'b0, addr: ptr[5:0], target: TGT_GENERAL};
                end
            end
            default: begin
                if (idx == 3'd0) begin
                    s = '{valid: 1'b1, write: 1'b1, addr: ptr[5:0], target: TGT_GENERAL};
                end
            end
        endcase
        return s;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        merge = old;
        if (strb[0]) begin
            merge[7:0] = d[7:0];
        end
        if (strb[1]) begin
            merge[15:8] = d[15:8];
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_CONTROL) || (a == OFF_CONFIG) || (a == OFF_BASE) ||
                 (a == OFF_STATION0) || (a == OFF_STATION1) || (a == OFF_STATION2) ||
                 (a == OFF_POINTER) || (a == OFF_GENERAL) || (a == OFF_STATUS);
    endfunction

    assign cur_step = plan(job, strap_s2, step_idx, pointer_reg);

    // pins from outside pass two flip-flops
    always_ff @(posedge aclk) begin
        strap_s1 <= board_offset_straps;
        strap_s2 <= strap_s1;
        present_s1 <= nvmem_present_pin;
        present_s2 <= present_s1;
        done_s1 <= done_tgl;
        done_s2 <= done_s1;
    end

    // axi write channel capture
    logic wr_fire, wr_accept, ctl_write;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_accept = wr_fire && !busy;
    assign ctl_write = wr_accept && aw_addr == OFF_CONTROL && w_strb[0];
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read channel; one cycle from address to data
    logic [7:0] ra;
    assign ra = {s_axi_araddr[7:2], 2'b00};
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= 32'h0000_0000;
            if (ra == OFF_CONTROL) begin
                // both triggers read high for the whole transfer
                s_axi_rdata[CTL_SELECT_BIT] <= select_mode;
                s_axi_rdata[CTL_LOAD_BIT] <= busy;
                s_axi_rdata[CTL_SAVE_BIT] <= busy;
            end else if (ra == OFF_STATUS) begin
                s_axi_rdata[4:0] <= {busy, present_s2, strap_s2};
            end else if (!busy) begin
                case (ra)
                    OFF_CONFIG: s_axi_rdata[15:0] <= config_reg;
                    OFF_BASE: s_axi_rdata[15:0] <= base_reg;
                    OFF_STATION0: s_axi_rdata[15:0] <= station_word[0];
                    OFF_STATION1: s_axi_rdata[15:0] <= station_word[1];
                    OFF_STATION2: s_axi_rdata[15:0] <= station_word[2];
                    OFF_POINTER: s_axi_rdata[15:0] <= pointer_reg;
                    OFF_GENERAL: s_axi_rdata[15:0] <= general_reg;
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // register file: software writes when idle, loaded words when a read step ends
    logic load_done;
    assign load_done = seq == Q_WAIT && done_s2 != done_seen && !cmd.write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg <= CONFIG_RESET;
            base_reg <= BASE_RESET;
            pointer_reg <= POINTER_RESET;
            general_reg <= GENERAL_RESET;
            station_word[0] <= STATION_RESET;
            station_word[1] <= STATION_RESET;
            station_word[2] <= STATION_RESET;
            select_mode <= 1'b0;
        end else if (load_done) begin
            case (cur_step.target)
                TGT_CONFIG: config_reg <= link_rdata;
                TGT_BASE: base_reg <= link_rdata;
                TGT_STATION0: station_word[0] <= link_rdata;
                TGT_STATION1: station_word[1] <= link_rdata;
                TGT_STATION2: station_word[2] <= link_rdata;
                default: general_reg <= link_rdata;
            endcase
        end else if (wr_accept) begin
            case (aw_addr)
                OFF_CONTROL: if (w_strb[0]) select_mode <= w_data[CTL_SELECT_BIT];
                OFF_CONFIG: config_reg <= merge(config_reg, w_data, w_strb);
                OFF_BASE: base_reg <= merge(base_reg, w_data, w_strb);
                OFF_STATION0: station_word[0] <= merge(station_word[0], w_data, w_strb);
                OFF_STATION1: station_word[1] <= merge(station_word[1], w_data, w_strb);
                OFF_STATION2: station_word[2] <= merge(station_word[2], w_data, w_strb);
                OFF_POINTER: pointer_reg <= merge(pointer_reg, w_data, w_strb);
                OFF_GENERAL: general_reg <= merge(general_reg, w_data, w_strb);
                default: config_reg <= config_reg;
            endcase
        end
    end

    assign config_value = config_reg;
    assign base_value = base_reg;
    assign station_address = {station_word[2], station_word[1], station_word[0]};

    // job sequencer; the control bits themselves never reach the memory
    logic start_load, start_save;
    assign start_load = ctl_write && w_data[CTL_LOAD_BIT];
    assign start_save = ctl_write && !w_data[CTL_LOAD_BIT] && w_data[CTL_SAVE_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq <= Q_BOOT;
            busy <= 1'b1;
            job <= JOB_LOAD_NORMAL;
            step_idx <= 3'd0;
            boot_cnt <= 2'd0;
            req_tgl <= 1'b0;
            done_seen <= 1'b0;
            cmd <= '0;
        end else begin
            case (seq)
                Q_BOOT: begin
                    // straps and presence need their synchronisers filled first
                    boot_cnt <= boot_cnt + 2'd1;
                    if (boot_cnt == BOOT_SETTLE) begin
                        step_idx <= 3'd0;
                        job <= JOB_LOAD_NORMAL;
                        seq <= present_s2 ? Q_STEP : Q_IDLE;
                        busy <= present_s2;
                    end
                end
                Q_IDLE: begin
                    if ((start_load || start_save) && present_s2) begin
                        busy <= 1'b1;
                        step_idx <= 3'd0;
                        seq <= Q_STEP;
                        if (w_data[CTL_SELECT_BIT]) begin
                            job <= start_load ? JOB_LOAD_GENERAL : JOB_SAVE_GENERAL;
                        end else begin
                            job <= start_load ? JOB_LOAD_NORMAL : JOB_SAVE_NORMAL;
                        end
                    end
                end
                Q_STEP: begin
                    if (!cur_step.valid) begin
                        if (step_idx >= 3'd4) begin
                            busy <= 1'b0;
                            seq <= Q_IDLE;
                        end else begin
                            step_idx <= step_idx + 3'd1;
                        end
                    end else begin
                        cmd.write <= cur_step.write;
                        cmd.addr <= cur_step.addr;
                        case (cur_step.target)
                            TGT_CONFIG: cmd.data <= config_reg;
                            TGT_BASE: cmd.data <= base_reg;
                            default: cmd.data <= general_reg;
                        endcase
                        req_tgl <= ~req_tgl;
                        seq <= Q_WAIT;
                    end
                end
                Q_WAIT: begin
                    if (done_s2 != done_seen) begin
                        done_seen <= done_s2;
                        step_idx <= step_idx + 3'd1;
                        seq <= Q_STEP;
                    end
                end
                default: seq <= Q_IDLE;
            endcase
        end
    end

    // link domain synchronisers
    always_ff @(posedge link_clk) begin
        lrst_s1 <= aresetn;
        lrst_s2 <= lrst_s1;
        req_s1 <= req_tgl;
        req_s2 <= req_s1;
        do_s1 <= nvm_do;
        do_s2 <= do_s1;
    end

    // serial engine: four link cycles a bit, clock high in phases 1 and 2;
    // data-out is sampled in phase 3 so the synchroniser delay is covered
    assign nvm_di = shreg[24];

    always_ff @(posedge link_clk) begin
        if (!lrst_s2) begin
            eng <= E_IDLE;
            ph <= 2'd0;
            bit_cnt <= 5'd0;
            shreg <= 25'h000_0000;
            link_rdata <= 16'h0000;
            stage <= 2'd0;
            done_tgl <= 1'b0;
            req_seen <= 1'b0;
            nvm_cs <= 1'b0;
            nvm_sk <= 1'b0;
        end else begin
            ph <= (eng == E_IDLE) ? 2'd0 : ph + 2'd1;
            nvm_sk <= (eng == E_SHIFT || eng == E_READ) && (ph == 2'd0 || ph == 2'd1);
            case (eng)
                E_IDLE: begin
                    if (req_s2 != req_seen) begin
                        req_seen <= req_s2;
                        nvm_cs <= 1'b1;
                        bit_cnt <= HEAD_BITS;
                        eng <= E_SHIFT;
                        if (cmd.write) begin
                            stage <= 2'd0;
                            shreg <= {FRAME_ENABLE, ENABLE_ADDR, 16'h0000};
                        end else begin
                            stage <= 2'd3;
                            shreg <= {FRAME_READ, cmd.addr, 16'h0000};
                        end
                    end
                end
                E_SHIFT: begin
                    if (ph == 2'd3) begin
                        shreg <= {shreg[23:0], 1'b0};
                        bit_cnt <= bit_cnt - 5'd1;
                        if (bit_cnt == 5'd1) begin
                            if (stage == 2'd3) begin
                                bit_cnt <= WORD_BITS;
                                eng <= E_READ;
                            end else begin
                                stage <= stage + 2'd1;
                                nvm_cs <= 1'b0;
                                eng <= E_GAP;
                            end
                        end
                    end
                end
                E_READ: begin
                    if (ph == 2'd3) begin
                        link_rdata <= {link_rdata[14:0], do_s2};
                        bit_cnt <= bit_cnt - 5'd1;
                        if (bit_cnt == 5'd1) begin
                            nvm_cs <= 1'b0;
                            eng <= E_GAP;
                        end
                    end
                end
                E_GAP: begin
                    if (ph == 2'd3) begin
                        if (stage == 2'd1) begin
                            nvm_cs <= 1'b1;
                            bit_cnt <= WRITE_BITS;
                            shreg <= {FRAME_WRITE, cmd.addr, cmd.data};
                            eng <= E_SHIFT;
                        end else if (stage == 2'd2) begin
                            nvm_cs <= 1'b1;
                            eng <= E_WAIT;
                        end else begin
                            eng <= E_DONE;
                        end
                    end
                end
                E_WAIT: begin
                    // the memory raises data-out once the word is programmed
                    if (ph == 2'd3 && do_s2) begin
                        nvm_cs <= 1'b0;
                        eng <= E_DONE;
                    end
                end
                E_DONE: begin
                    done_tgl <= ~done_tgl;
                    eng <= E_IDLE;
                end
                default: eng <= E_IDLE;
            endcase
        end
    end
endmodule

/* sim/scl_nvm_model.sv */
/* three-wire serial memory of 64 sixteen-bit words: read, enable, write frames
   assumes chip select active high and bits taken on the rising serial clock */
`timescale 1ns/1ns
module scl_nvm_model (
    input wire logic link_clk,
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    output logic dout
);
    logic [15:0] mem [64];
    logic [24:0] sh = '0;
    logic [15:0] rd_w = '0;
    logic q = 1'b0, rdg = 1'b0, we = 1'b0, rdy = 1'b1;
    int n = 0;
    time t_rdy = 0;
    // a released line shows the inverse of its last bit, never a stable guess
    assign dout = cs ? (rdg ? q : rdy) : ~q;
    always @(posedge link_clk) rdy <= ($time >= t_rdy);
    always @(posedge sk or negedge cs) begin
        if (!cs) begin
            if (n == 25 && sh[24:22] == 3'b101 && we) begin
                mem[sh[21:16]] <= sh[15:0];
                t_rdy <= $time + 3000;
            end
            if (n == 9 && sh[8:6] == 3'b100) we <= (sh[5:4] == 2'b11);
            n <= 0;
            rdg <= 1'b0;
        end else begin
            sh <= {sh[23:0], di};
            n <= n + 1;
            if (n == 8 && sh[7:5] == 3'b110) begin
                rdg <= 1'b1;
                rd_w <= mem[{sh[4:0], di}];
                q <= 1'b0;
            end
            if (rdg && n >= 9 && n <= 24) q <= rd_w[24-n];
        end
    end
endmodule

/* sim/scl_loader_asserts.sv */
/* port relations of the serial configuration loader
   assumes it is bound onto every scl_loader instance */
`timescale 1ns/1ns
module scl_loader_asserts
    import scl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic nvmem_present_pin,
    input wire logic nvm_cs,
    input wire logic nvm_sk
);
    logic rd_go;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    AST_R_ANSWER: assert property (rd_go |=> s_axi_rvalid)
        else $error("read not answered");
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address not held after it was taken");
    AST_BUSY_BITS: assert property (rd_go && s_axi_araddr == OFF_CONTROL && nvm_cs |=>
        s_axi_rdata[2:1] == 2'b11) else $error("triggers low during transfer");
    AST_BLOCKED: assert property (rd_go && s_axi_araddr == OFF_CONFIG && nvm_cs |=>
        s_axi_rdata == 32'h0000_0000) else $error("read not blocked");
    AST_QUIET: assert property ((!nvmem_present_pin) [*4] |-> !nvm_cs)
        else $error("memory selected while absent");
    AST_BOOT: assert property ($rose(aresetn) && nvmem_present_pin |-> ##[1:60] nvm_cs)
        else $error("no fetch after reset");
    AST_SK_IDLE: assert property (!nvm_cs |-> !nvm_sk)
        else $error("serial clock outside frame");
    cover property (rd_go && s_axi_araddr == OFF_CONTROL && nvm_cs);
    cover property ($rose(nvm_cs));
    cover property (s_axi_bvalid);
endmodule
bind scl_loader scl_loader_asserts u_asserts (.*);

/* sim/test_scl_loader.sv */
/* register-level bench of the serial configuration loader
   assumes the memory model on the serial pins and a free link clock */
`timescale 1ns/1ns
module test_scl_loader;
    import scl_pkg::*;
    logic aclk, link_clk, aresetn, awv, wv, arv, pres, cs, sk, di, dout, awr, wr_y, bv, arr, rv;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdt, rdv;
    logic [1:0] br, rr, rsp;
    logic [2:0] st;
    logic [15:0] cfg, bas;
    logic [47:0] sta;
    int n_errors = 0, num_checks = 0;
    scl_loader dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_y), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(1'h1), .board_offset_straps(st), .nvmem_present_pin(pres),
        .config_value(cfg), .base_value(bas), .station_address(sta), .link_clk(link_clk),
        .nvm_cs(cs), .nvm_sk(sk), .nvm_di(di), .nvm_do(dout));
    scl_nvm_model m (.link_clk(link_clk), .cs(cs), .sk(sk), .di(di), .dout(dout));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        report_and_stop;
    end
    task automatic chk(input logic [79:0] g, input logic [79:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        awa <= a;
        wd <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do @(posedge aclk); while (awr !== 1'b1 || wr_y !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge aclk); while (bv !== 1'b1);
        rsp = br;
    endtask
    task automatic rdd(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        rdv = rdt;
        rsp = rr;
    endtask
    task automatic poll;
        do rdd(OFF_CONTROL); while (rdv[2:1] !== 2'b00);
    endtask
    task automatic rst;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {aresetn, awv, wv, arv, awa, ara, wd} = '0;
        st = 3'h2;
        pres = 1'b1;
        for (int i = 0; i < 64; i++) m.mem[i] = 16'hc000 + 16'(i);
        rst;
        poll;
        chk(cfg, 16'hc008);
        rdd(OFF_BASE);
        chk(rdv, 16'hc009);
        chk(sta, 48'hc022_c021_c020);
        $display("boot test done");
        st <= 3'h1;
        m.mem[32] = 16'h0a0a;
        wrr(OFF_CONTROL, 16'h0002);
        rdd(OFF_CONTROL);
        chk(rdv[2:1], 2'b11);
        rdd(OFF_CONFIG);
        chk(rdv, 48'h0);
        wrr(OFF_POINTER, 16'h1111);
        poll;
        rdd(OFF_POINTER);
        chk({bas, sta[15:0], rdv[15:0]}, 48'hc005_0a0a_0000);
        $display("reload test done");
        wrr(OFF_CONFIG, 16'h1234);
        wrr(OFF_BASE, 16'h5678);
        wrr(OFF_CONTROL, 16'h0004);
        poll;
        chk({m.mem[4], m.mem[5], m.mem[32]}, 48'h1234_5678_0a0a);
        wrr(OFF_POINTER, 16'h00c5);
        wrr(OFF_CONTROL, 16'h0003);
        poll;
        rdd(OFF_GENERAL);
        chk(rdv, 16'h5678);
        wrr(OFF_GENERAL, 16'hbeef);
        wrr(OFF_CONTROL, 16'h0005);
        poll;
        chk({rdv[2:0], m.mem[5]}, 19'h1_beef);
        rdd(8'h40);
        chk(rsp, RESP_SLVERR);
        wrr(8'h44, 16'h0000);
        chk(rsp, RESP_SLVERR);
        $display("store test done");
        st <= 3'h7;
        rst;
        poll;
        chk({cfg, bas, sta}, 80'h0000_0300_c022_c021_0a0a);
        pres <= 1'b0;
        rst;
        repeat (8) @(posedge aclk);
        wrr(OFF_CONTROL, 16'h0002);
        rdd(OFF_STATUS);
        chk({rdv[4:0], sta[31:0], bas}, {5'h07, 48'h0300});
        $display("default test done");
        report_and_stop;
    end
endmodule
